// ==== verilog/lcm_pkg.sv ====
// Summary of operation
// - white current code, 0.1 mA steps, resets AFh
// - map bits 7:6 pick white duty source
// - map bits 5:4 pick red duty source
// - map bits 3:2 pick green duty source
// - map bits 1:0 pick blue duty source
// - mapping register at 70h, resets 39h
// - program memory 10h-6Fh, cleared on reset
// - decode command class from top bits
// - trigger carries wait and send masks
// - host clears config bit 6 for 256 Hz
// - host writes 00 to clock-source bits
// - host sets config bit 5 for power save
// - host configures device after power-up
// - two pins select one of four addresses
// - system feeds shared external 32 kHz clock
// - per-engine irq flags, cleared by status read
// - white direct duty register drives white output when map bits 7:6 are 00
package lcm_pkg;
    localparam logic [7:0] ADR_BLUE_PWM  = 8'h02;
    localparam logic [7:0] ADR_GREEN_PWM = 8'h03;
    localparam logic [7:0] ADR_RED_PWM   = 8'h04;
    localparam logic [7:0] ADR_CONFIG    = 8'h08;
    localparam logic [7:0] ADR_STATUS    = 8'h0c;
    localparam logic [7:0] ADR_WHITE_PWM = 8'h0e;
    localparam logic [7:0] ADR_WHITE_CUR = 8'h0f;
    localparam logic [7:0] ADR_PROG_LO   = 8'h10;
    localparam logic [7:0] ADR_PROG_HI   = 8'h6f;
    localparam logic [7:0] ADR_MAP       = 8'h70;
    localparam logic [7:0] RST_WHITE_CUR = 8'haf;
    localparam logic [7:0] RST_MAP       = 8'h39;
    localparam logic [7:0] RST_ZERO      = 8'h00;
    localparam int         PROG_BYTES    = 96;
    localparam int         ENG_WORDS     = 16;
    localparam int         CFG_FAST_BIT  = 6;
    localparam int         CFG_PSAVE_BIT = 5;
    localparam logic [1:0] CLK_SRC_EXT   = 2'h0;
    localparam logic [2:0] OP_BRANCH     = 3'h5;
    localparam logic [2:0] OP_END        = 3'h6;
    localparam logic [2:0] OP_TRIGGER    = 3'h7;
    localparam logic [6:0] BUS_ADDR_BASE = 7'h30; // arbitrary base
    // controller registers on wishbone (word addresses)
    localparam logic [3:0] WB_CTRL       = 4'h0;
    localparam logic [3:0] WB_ADDR       = 4'h1;
    localparam logic [3:0] WB_WDATA      = 4'h2;
    localparam logic [3:0] WB_RDATA      = 4'h3;
    localparam logic [3:0] WB_STAT       = 4'h4;
    localparam logic [3:0] WB_SEL        = 4'h5;
    typedef enum logic [7:0] {
        CMD_GOSTART = 8'h01, CMD_RAMP_OR_WAIT_COMMAND = 8'h02, CMD_SETPWM = 8'h04,
        CMD_BRANCH  = 8'h08, CMD_END      = 8'h10, CMD_TRIGGER = 8'h20,
        CMD_ILLEGAL = 8'h40
    } lcm_cmd_t;
    function automatic lcm_cmd_t decode_cmd(input logic [15:0] w);
        if (w == 16'h0000) return CMD_GOSTART;
        else if (!w[15] && w[14] && w[13:8] == 6'h00) return CMD_SETPWM;
        else if (!w[15]) return CMD_RAMP_OR_WAIT_COMMAND;
        else if (w[15:13] == OP_BRANCH) return CMD_BRANCH;
        else if (w[15:13] == OP_END) return CMD_END;
        else if (w[15:13] == OP_TRIGGER) return CMD_TRIGGER;
        else return CMD_ILLEGAL;
    endfunction : decode_cmd
endpackage : lcm_pkg

// ==== verilog/lcm_if.sv ====
`timescale 1ns/1ps
// register-level link: one access per req/ack pair, chip address carried along
interface lcm_if;
    logic       req;     // host request, held until ack
    logic       we;      // write
    logic [6:0] chipAdr; // bus address of target
    logic [7:0] adr;     // register address
    logic [7:0] wdata;   // write data
    logic       ack;     // device answer, one cycle
    logic       ackOe;   // device drives ack/rdata
    logic [7:0] rdata;   // read data
    modport host (output req, we, chipAdr, adr, wdata, input ack, ackOe, rdata);
    modport dev  (input req, we, chipAdr, adr, wdata, output ack, ackOe, rdata);
endinterface : lcm_if

// ==== verilog/lcm_device.sv ====
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
module lcm_device #(
    parameter int TICK_DIV = 4 // system cycles per engine step
) (
    input  wire logic sys_clk,  // clock
    input  wire logic rst_n,    // sync reset
    lcm_if.dev        link,     // register link
    input  wire logic busAddressPin0, // address select 0
    input  wire logic busAddressPin1, // address select 1
    output logic [7:0] whiteDuty, // duty per output
    output logic [7:0] redDuty,
    output logic [7:0] greenDuty,
    output logic [7:0] blueDuty,
    output logic [7:0] whiteCurrent, // current code
    output logic [7:0] configBits,   // config register
    output logic [2:0] engineRunning // engine run states
);
    // tick counter is 8 bits wide
    if (TICK_DIV < 1 || TICK_DIV > 256) begin : g_bad_tick
        $error("TICK_DIV out of range");
    end
    typedef struct packed {
        logic [7:0]  cur;
        logic [7:0]  map;
        logic [7:0]  cfg;
        logic [3:0][7:0] dpwm; // 0 blue,1 green,2 red,3 white
        logic [lcm_pkg::PROG_BYTES-1:0][7:0] mem;
        logic [2:0]  irq;
        logic [2:0]  run;
        logic [2:0][3:0] pc;
        logic [2:0][7:0] epwm;
        logic [2:0][5:0] loops;
        logic [7:0]  tick;
        logic        ack;
        logic [7:0]  rdata;
    } lcm_dev_t;
    lcm_dev_t s_r, s_nxt;
    logic [6:0] myAdr;
    logic       hit;
    assign myAdr = lcm_pkg::BUS_ADDR_BASE | {5'h00, busAddressPin1, busAddressPin0};
    assign hit = link.req && !s_r.ack && link.chipAdr == myAdr;
    function automatic logic [7:0] pick(input logic [1:0] sel, input logic [7:0] direct,
                                        input logic [2:0][7:0] e);
        if (sel == 2'h0) return direct;
        else return e[sel - 2'h1];
    endfunction : pick
    always_comb begin
        logic [7:0] a;
        logic [15:0] w;
        int i;
        a = link.adr;
        w = 16'h0000;
        i = 0;
        s_nxt = s_r;
        s_nxt.ack = 1'b0;
        // engine step each tick, one command per engine
        s_nxt.tick = (s_r.tick == 8'(TICK_DIV - 1)) ? 8'h00 : s_r.tick + 8'h01;
        if (s_r.tick == 8'h00) begin
            for (i = 0; i < 3; i++) begin
                w = {s_r.mem[i*32 + 2*s_r.pc[i]], s_r.mem[i*32 + 2*s_r.pc[i] + 1]};
                if (s_r.run[i]) begin
                    s_nxt.pc[i] = s_r.pc[i] + 4'h1;
                    case (lcm_pkg::decode_cmd(w))
                        lcm_pkg::CMD_GOSTART: s_nxt.pc[i] = 4'h0;
                        lcm_pkg::CMD_SETPWM: s_nxt.epwm[i] = w[7:0];
                        lcm_pkg::CMD_RAMP_OR_WAIT_COMMAND: begin
                            // sign at bit 7, increment count in bits 6:0
                            if (w[6:0] != 7'h00)
                                s_nxt.epwm[i] = w[7] ? s_r.epwm[i] - 8'h01
                                                     : s_r.epwm[i] + 8'h01;
                        end
                        lcm_pkg::CMD_BRANCH: begin
                            if (w[12:7] == 6'h00 || s_r.loops[i] + 6'h01 < w[12:7]) begin
                                s_nxt.loops[i] = s_r.loops[i] + 6'h01;
                                s_nxt.pc[i] = w[3:0];
                            end else s_nxt.loops[i] = 6'h00;
                        end
                        lcm_pkg::CMD_END: begin
                            s_nxt.run[i] = 1'b0;
                            if (w[12]) s_nxt.irq[i] = 1'b1;
                            if (w[11]) s_nxt.pc[i] = 4'h0;
                        end
                        lcm_pkg::CMD_TRIGGER: begin
                            // no partner engines here: wait mask w[12:7] ignored
                        end
                        default: s_nxt.run[i] = 1'b0;
                    endcase
                end
            end
        end
        if (hit) begin
            s_nxt.ack = 1'b1;
            s_nxt.rdata = 8'h00;
            if (link.we) begin
                if (a == lcm_pkg::ADR_WHITE_CUR) s_nxt.cur = link.wdata;
                else if (a == lcm_pkg::ADR_MAP) s_nxt.map = link.wdata;
                else if (a == lcm_pkg::ADR_CONFIG) s_nxt.cfg = link.wdata;
                else if (a == lcm_pkg::ADR_BLUE_PWM) s_nxt.dpwm[0] = link.wdata;
                else if (a == lcm_pkg::ADR_GREEN_PWM) s_nxt.dpwm[1] = link.wdata;
                else if (a == lcm_pkg::ADR_RED_PWM) s_nxt.dpwm[2] = link.wdata;
                else if (a == lcm_pkg::ADR_WHITE_PWM) s_nxt.dpwm[3] = link.wdata;
                else if (a >= lcm_pkg::ADR_PROG_LO && a <= lcm_pkg::ADR_PROG_HI)
                    s_nxt.mem[a - lcm_pkg::ADR_PROG_LO] = link.wdata;
                // engine start: write nonzero to status runs engines in bits 2:0
                else if (a == lcm_pkg::ADR_STATUS) s_nxt.run = link.wdata[2:0];
            end else begin
                if (a == lcm_pkg::ADR_WHITE_CUR) s_nxt.rdata = s_r.cur;
                else if (a == lcm_pkg::ADR_MAP) s_nxt.rdata = s_r.map;
                else if (a == lcm_pkg::ADR_CONFIG) s_nxt.rdata = s_r.cfg;
                else if (a == lcm_pkg::ADR_BLUE_PWM) s_nxt.rdata = s_r.dpwm[0];
                else if (a == lcm_pkg::ADR_GREEN_PWM) s_nxt.rdata = s_r.dpwm[1];
                else if (a == lcm_pkg::ADR_RED_PWM) s_nxt.rdata = s_r.dpwm[2];
                else if (a == lcm_pkg::ADR_WHITE_PWM) s_nxt.rdata = s_r.dpwm[3];
                else if (a >= lcm_pkg::ADR_PROG_LO && a <= lcm_pkg::ADR_PROG_HI)
                    s_nxt.rdata = s_r.mem[a - lcm_pkg::ADR_PROG_LO];
                else if (a == lcm_pkg::ADR_STATUS) begin
                    // flag order: engine 1 at bit 2
                    s_nxt.rdata = {5'h00, s_r.irq[0], s_r.irq[1], s_r.irq[2]};
                    // a flag set this very cycle survives the clear
                    s_nxt.irq = s_nxt.irq & ~s_r.irq;
                end
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.cur <= lcm_pkg::RST_WHITE_CUR;
            s_r.map <= lcm_pkg::RST_MAP;
        end else s_r <= s_nxt;
    end
    assign link.ack = s_r.ack;
    assign link.ackOe = s_r.ack;
    assign link.rdata = s_r.rdata;
    assign whiteDuty = pick(s_r.map[7:6], s_r.dpwm[3], s_r.epwm);
    assign redDuty   = pick(s_r.map[5:4], s_r.dpwm[2], s_r.epwm);
    assign greenDuty = pick(s_r.map[3:2], s_r.dpwm[1], s_r.epwm);
    assign blueDuty  = pick(s_r.map[1:0], s_r.dpwm[0], s_r.epwm);
    assign whiteCurrent = s_r.cur;
    assign configBits = s_r.cfg;
    assign engineRunning = s_r.run;
endmodule : lcm_device

// ==== verilog/lcm_host.sv ====
`timescale 1ns/1ps
module lcm_host (
    input  wire logic        sys_clk,  // clock
    input  wire logic        rst_n,    // sync reset
    lcm_if.host              link,     // register link
    input  wire logic        wb_cyc_i, // wishbone cycle
    input  wire logic        wb_stb_i, // wishbone strobe
    input  wire logic        wb_we_i,  // wishbone write
    input  wire logic [3:0]  wb_sel_i, // byte enables
    input  wire logic [5:0]  wb_adr_i, // byte address
    input  wire logic [31:0] wb_dat_i, // write data
    output logic [31:0]      wb_dat_o, // read data
    output logic             wb_ack_o  // ack
);
    typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_WAIT = 2'b10} lcm_hst_t;
    typedef struct packed {
        lcm_hst_t   st;
        logic [7:0] adr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic [1:0] chipSel;
        logic       we;
        logic       done;
        logic       ack;
        logic [31:0] dat;
    } lcm_host_t;
    lcm_host_t s_r, s_nxt;
    logic [3:0] idx;
    assign idx = wb_adr_i[5:2];
    always_comb begin
        s_nxt = s_r;
        s_nxt.ack = 1'b0;
        case (s_r.st)
            ST_IDLE: ;
            ST_WAIT: begin
                if (link.ack) begin
                    s_nxt.rdata = link.rdata;
                    s_nxt.done = 1'b1;
                    s_nxt.st = ST_IDLE;
                end
            end
            default: s_nxt.st = ST_IDLE;
        endcase
        if (wb_cyc_i && wb_stb_i && !s_r.ack) begin
            s_nxt.ack = 1'b1;
            s_nxt.dat = 32'h00000000;
            if (idx == lcm_pkg::WB_CTRL) begin
                // one device access per write; software builds config
                if (wb_we_i && wb_sel_i[0] && wb_dat_i[0] && s_r.st == ST_IDLE) begin
                    s_nxt.we = wb_dat_i[1];
                    s_nxt.done = 1'b0;
                    s_nxt.st = ST_WAIT;
                end
            end else if (idx == lcm_pkg::WB_ADDR) begin
                if (wb_we_i && wb_sel_i[0]) s_nxt.adr = wb_dat_i[7:0];
                s_nxt.dat = {24'h000000, s_r.adr};
            end else if (idx == lcm_pkg::WB_WDATA) begin
                if (wb_we_i && wb_sel_i[0]) s_nxt.wdata = wb_dat_i[7:0];
                s_nxt.dat = {24'h000000, s_r.wdata};
            end else if (idx == lcm_pkg::WB_RDATA) begin
                s_nxt.dat = {24'h000000, s_r.rdata};
            end else if (idx == lcm_pkg::WB_STAT) begin
                s_nxt.dat = {30'h00000000, s_r.done, s_r.st == ST_WAIT};
            end else if (idx == lcm_pkg::WB_SEL) begin
                if (wb_we_i && wb_sel_i[0]) s_nxt.chipSel = wb_dat_i[1:0];
                s_nxt.dat = {30'h00000000, s_r.chipSel};
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.st <= ST_IDLE;
        end else s_r <= s_nxt;
    end
    // config values for 256 Hz, external clock, power save are software's
    // external 32 kHz sharing is a board matter
    assign link.req = (s_r.st == ST_WAIT);
    assign link.we = s_r.we;
    assign link.chipAdr = lcm_pkg::BUS_ADDR_BASE | {5'h00, s_r.chipSel};
    assign link.adr = s_r.adr;
    assign link.wdata = s_r.wdata;
    assign wb_ack_o = s_r.ack;
    assign wb_dat_o = s_r.dat;
endmodule : lcm_host

// ==== sim/lcm_properties.sv ====
`timescale 1ns/1ps
module lcm_properties (
    input wire logic       sys_clk, // clock
    input wire logic       rst_n,   // sync reset
    input wire logic       req,     // request
    input wire logic       we,      // write
    input wire logic [6:0] chipAdr, // target
    input wire logic [7:0] adr,     // register
    input wire logic [7:0] wdata,   // write data
    input wire logic       ack,     // answer
    input wire logic       ackOe,   // answer drive
    input wire logic [7:0] rdata    // read data
);
    logic [7:0] mapSeen_r; // map as last written over the link
    always_ff @(posedge sys_clk) begin
        if (!rst_n) mapSeen_r <= lcm_pkg::RST_MAP;
        else if (ack && we && adr == lcm_pkg::ADR_MAP) mapSeen_r <= wdata;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_ack_single: assert property (ack |=> !ack)
        else $error("ack wider than one cycle");
    a_ack_needs_req: assert property (ack |-> req)
        else $error("ack without request");
    a_oe_follows_ack: assert property (ackOe == ack)
        else $error("drive enable apart from ack");
    // a refused address keeps waiting, so either branch may hold
    a_ack_prompt: assert property ($rose(req) |=> ack or (req && !ack)[*3])
        else $error("ack late");
    a_req_drops: assert property (ack |=> !req)
        else $error("request kept after ack");
    a_req_held: assert property (req && !ack |=> req)
        else $error("request dropped before ack");
    a_req_steady: assert property (req && !ack |=> $stable({we, chipAdr, adr, wdata}))
        else $error("request changed while waiting");
    a_map_readback: assert property (ack && !we && adr == lcm_pkg::ADR_MAP |-> rdata == mapSeen_r)
        else $error("map read differs");
    c_write: cover property (ack && we);
    c_map_read: cover property (ack && !we && adr == lcm_pkg::ADR_MAP);
    c_refused: cover property ((req && !ack)[*3]);
endmodule : lcm_properties

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    logic        sys_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        wbCyc   = 1'b0;
    logic        wbStb   = 1'b0;
    logic        wbWe    = 1'b0;
    logic [5:0]  wbAdr   = 6'h00;
    logic [31:0] wbDatW  = 32'h00000000;
    logic [31:0] wbDatR;
    logic        wbAck;
    logic [1:0]  pins    = 2'h0;
    logic [7:0]  whiteDuty, redDuty, greenDuty, blueDuty, whiteCur, cfgBits;
    logic [2:0]  engRun;
    int          miscompares = 0;
    int          samples_checked = 0;
    lcm_if link ();
    always #10 sys_clk = ~sys_clk;
    lcm_host i_lcm_host (.sys_clk(sys_clk), .rst_n(rst_n), .link(link), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_sel_i(4'h1), .wb_adr_i(wbAdr),
        .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck));
    lcm_device #(.TICK_DIV(4)) i_lcm_device (.sys_clk(sys_clk), .rst_n(rst_n), .link(link),
        .busAddressPin0(pins[0]), .busAddressPin1(pins[1]), .whiteDuty(whiteDuty),
        .redDuty(redDuty), .greenDuty(greenDuty), .blueDuty(blueDuty),
        .whiteCurrent(whiteCur), .configBits(cfgBits), .engineRunning(engRun));
    lcm_properties i_lcm_properties (.sys_clk(sys_clk), .rst_n(rst_n), .req(link.req),
        .we(link.we), .chipAdr(link.chipAdr), .adr(link.adr), .wdata(link.wdata),
        .ack(link.ack), .ackOe(link.ackOe), .rdata(link.rdata));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= w;
        wbAdr <= {a, 2'b00};
        wbDatW <= d;
        // ack and read data are taken at the rising edge that samples ack high
        do begin
            @(posedge sys_clk);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        if (n >= 50) begin
            miscompares++;
            complete_run();
        end
        q = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge sys_clk);
    endtask : wb
    task automatic dev(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        logic [31:0] s;
        int n;
        wb(1'b1, lcm_pkg::WB_ADDR, {24'h0, a}, s);
        wb(1'b1, lcm_pkg::WB_WDATA, {24'h0, d}, s);
        wb(1'b1, lcm_pkg::WB_CTRL, {30'h0, w, 1'b1}, s);
        n = 0;
        do begin
            wb(1'b0, lcm_pkg::WB_STAT, 32'h0, s);
            n++;
        end while (s[1:0] !== 2'b10 && n < 20);
        if (n >= 20) begin
            miscompares++;
            complete_run();
        end
        wb(1'b0, lcm_pkg::WB_RDATA, 32'h0, s);
        q = s[7:0];
    endtask : dev
    task automatic start(input logic [1:0] sel);
        logic [31:0] s;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        wb(1'b1, lcm_pkg::WB_SEL, {30'h0, sel}, s);
    endtask : start
    initial begin
        logic [31:0] s;
        logic [7:0]  r, m, x;
        logic [7:0]  dir[4], eng[4];
        logic [7:0]  adrs[4];
        int          n;
        s = $urandom(97167);
        pins = s[1:0];
        adrs = '{lcm_pkg::ADR_WHITE_PWM, lcm_pkg::ADR_RED_PWM, lcm_pkg::ADR_GREEN_PWM,
                 lcm_pkg::ADR_BLUE_PWM};
        start(pins);
        dev(1'b0, lcm_pkg::ADR_WHITE_CUR, 8'h00, r);
        chk(r, lcm_pkg::RST_WHITE_CUR);
        dev(1'b0, lcm_pkg::ADR_MAP, 8'h00, r);
        chk(r, lcm_pkg::RST_MAP);
        dev(1'b0, lcm_pkg::ADR_PROG_LO, 8'h00, r);
        chk(r, 8'h00);
        dev(1'b0, lcm_pkg::ADR_PROG_HI, 8'h00, r);
        chk(r, 8'h00);
        wb(1'b0, 4'hf, 32'h0, s);
        chk(s, 32'h0);
        $display("reset values done");
        for (int i = 0; i < 3; i++) begin
            x = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
            dev(1'b1, lcm_pkg::ADR_WHITE_CUR, x, r);
            dev(1'b0, lcm_pkg::ADR_WHITE_CUR, 8'h00, r);
            chk(r, x);
            chk(whiteCur, x);
        end
        dev(1'b1, lcm_pkg::ADR_CONFIG, 8'h20, r);
        chk(cfgBits, 8'h20);
        $display("current and config done");
        for (int i = 0; i < 4; i++) begin
            dir[i] = 8'($urandom);
            eng[i] = 8'($urandom);
            dev(1'b1, adrs[i], dir[i], r);
        end
        // each engine: set-PWM to its value, then end with interrupt
        for (int k = 1; k < 4; k++) begin
            x = lcm_pkg::ADR_PROG_LO + 8'(32 * (k - 1));
            dev(1'b1, x, 8'h40, r);
            dev(1'b1, x + 8'h01, eng[k], r);
            dev(1'b1, x + 8'h02, 8'hd0, r);
            dev(1'b1, x + 8'h03, 8'h00, r);
        end
        dev(1'b1, lcm_pkg::ADR_STATUS, 8'h07, r);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (engRun !== 3'h0 && n < 200);
        chk(n < 200, 1'b1);
        dev(1'b0, lcm_pkg::ADR_STATUS, 8'h00, r);
        chk(r[2:0], 3'h7);
        dev(1'b0, lcm_pkg::ADR_STATUS, 8'h00, r);
        chk(r[2:0], 3'h0);
        for (int i = 0; i < 6; i++) begin
            m = (i < 4) ? {4{2'(i)}} : 8'($urandom);
            dev(1'b1, lcm_pkg::ADR_MAP, m, r);
            chk(whiteDuty, (m[7:6] == 2'h0) ? dir[0] : eng[m[7:6]]);
            chk(redDuty, (m[5:4] == 2'h0) ? dir[1] : eng[m[5:4]]);
            chk(greenDuty, (m[3:2] == 2'h0) ? dir[2] : eng[m[3:2]]);
            chk(blueDuty, (m[1:0] == 2'h0) ? dir[3] : eng[m[1:0]]);
        end
        $display("source mapping done");
        wb(1'b1, lcm_pkg::WB_SEL, {30'h0, ~pins}, s);
        wb(1'b1, lcm_pkg::WB_CTRL, 32'h1, s);
        repeat (3) begin
            wb(1'b0, lcm_pkg::WB_STAT, 32'h0, s);
            chk(s[0], 1'b1);
        end
        rst_n <= 1'b0;
        start(pins);
        dev(1'b0, lcm_pkg::ADR_MAP, 8'h00, r);
        chk(r, lcm_pkg::RST_MAP);
        chk(whiteCur, lcm_pkg::RST_WHITE_CUR);
        $display("address select and second reset done");
        complete_run();
    end
endmodule : testbench
